// >>> core/uar_core.sv
// asynchronous serial port: wishbone registers, receiver, fifo, transmitter
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "uar_regs.svh"
module uar_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        receive_line_pin_i,
  output logic             transmit_line_pin_o,
  output logic             transmit_line_pin_oe_n_o,
  output logic             irq_o
);
  import uar_pkg::*;

  // register state
  logic [7:0]    bcon_reg, bcon_next, icon_reg, icon_next, ipr_reg, ipr_next;
  logic [7:0]    pie_reg, pie_next, pir_reg, pir_next, rcs_reg, rcs_next;
  logic [7:0]    brl_reg, brl_next, brh_reg, brh_next, txs_reg, txs_next;
  logic          ack_reg, ack_next, irq_reg, irq_next;
  logic [31:0]   dat_reg, dat_next;
  // baud tick
  logic [15:0]   brg_reg, brg_next;
  logic          tick_reg, tick_next;
  // receiver
  uar_rx_state_e state_reg, state_next;
  logic [3:0]    tcnt_reg, tcnt_next, bcnt_reg, bcnt_next;
  logic [1:0]    samp_reg, samp_next;
  logic [8:0]    rsr_reg, rsr_next;
  logic          line_reg, line_next, prev_reg, prev_next;
  // fifo
  // each entry holds framing error, ninth bit and data byte
  uar_char_t     mem_reg [0:1];
  uar_char_t     mem_next [0:1];
  logic          wptr_reg, wptr_next, rptr_reg, rptr_next, overrun_error_reg, overrun_error_next;
  logic [1:0]    cnt_reg, cnt_next;
  // transmitter
  logic [8:0]    hold_reg, hold_next;
  logic          full_reg, full_next, txo_reg, txo_next, oen_reg, oen_next;
  logic [10:0]   tsr_reg, tsr_next;
  logic [3:0]    left_reg, left_next, ttck_reg, ttck_next;
  // decoded controls
  logic          serial_port_enable, continuous_receive_enable, sync, nine_rx, nine_tx, address_detect_enable, transmit_enable, rx_en, tx_en;
  logic          req, wr, rd, maj, receive_int_flag, transmit_int_flag, pop, push;
  logic [15:0]   div;
  uar_char_t     top, newc;

  // control fields and derived status
  assign serial_port_enable    = rcs_reg[`UAR_RS_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable    = rcs_reg[`UAR_RS_CONTINUOUS_RECEIVE_ENABLE];
  assign nine_rx = rcs_reg[`UAR_RS_RX9];
  assign address_detect_enable   = rcs_reg[`UAR_RS_ADDRESS_DETECT_ENABLE];
  assign sync    = txs_reg[`UAR_TS_SYNC];
  assign nine_tx = txs_reg[`UAR_TS_TX9];
  assign transmit_enable    = txs_reg[`UAR_TS_TRANSMIT_ENABLE];
  assign rx_en   = serial_port_enable & continuous_receive_enable & ~sync;
  assign tx_en   = serial_port_enable & transmit_enable & ~sync;
  assign receive_int_flag    = (cnt_reg != 2'h0);
  assign transmit_int_flag    = tx_en & ~full_reg;
  assign top     = mem_reg[rptr_reg];
  // divisor width follows the sixteen-bit select; high-speed select is storage only
  assign div     = bcon_reg[`UAR_BC_SIXTEEN_BIT_DIVISOR_SELECT] ? {brh_reg, brl_reg} : {8'h00, brl_reg};
  // majority of the samples at ticks seven, eight and nine of a cell
  assign maj     = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & line_reg) | (samp_reg[1] & line_reg);
  assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign rd      = req & ~wb_we_i;

  // next-state logic for registers, baud tick, receiver, fifo and transmitter
  always_comb begin
    bcon_next  = bcon_reg;
    icon_next  = icon_reg;
    ipr_next   = ipr_reg;
    pie_next   = pie_reg;
    pir_next   = pir_reg;
    rcs_next   = rcs_reg;
    brl_next   = brl_reg;
    brh_next   = brh_reg;
    txs_next   = txs_reg;
    ack_next   = req;
    dat_next   = 32'h0000_0000;
    brg_next   = brg_reg;
    tick_next  = 1'b0;
    state_next = state_reg;
    tcnt_next  = tcnt_reg;
    bcnt_next  = bcnt_reg;
    samp_next  = samp_reg;
    rsr_next   = rsr_reg;
    // pin corrected for polarity, then one more flop for the edge search
    line_next  = receive_line_pin_i ^ bcon_reg[`UAR_BC_RECEIVE_POLARITY];
    prev_next  = line_reg;
    mem_next   = mem_reg;
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    cnt_next   = cnt_reg;
    overrun_error_next  = overrun_error_reg;
    hold_next  = hold_reg;
    full_next  = full_reg;
    tsr_next   = tsr_reg;
    left_next  = left_reg;
    ttck_next  = ttck_reg;
    push       = 1'b0;
    pop        = 1'b0;
    newc       = {~maj, nine_rx ? rsr_reg[8] : 1'b0, nine_rx ? rsr_reg[7:0] : rsr_reg[8:1]};
    // register writes, read-only bits held by masks
    // the transmit holding address is taken by the transmitter below
    if (wr) begin
      case (wb_adr_i)
        `UAR_ADR_BCON: bcon_next = (bcon_reg & ~`UAR_WM_BCON) | (wb_dat_i[7:0] & `UAR_WM_BCON);
        `UAR_ADR_ICON: icon_next = wb_dat_i[7:0];
        `UAR_ADR_IPR:  ipr_next  = wb_dat_i[7:0];
        `UAR_ADR_PIE:  pie_next  = wb_dat_i[7:0];
        `UAR_ADR_PIR:  pir_next  = wb_dat_i[7:0] & `UAR_WM_PIR;
        `UAR_ADR_RCS:  rcs_next  = wb_dat_i[7:0] & `UAR_WM_RCS;
        `UAR_ADR_BRL:  brl_next  = wb_dat_i[7:0];
        `UAR_ADR_BRH:  brh_next  = wb_dat_i[7:0];
        `UAR_ADR_TXS:  txs_next  = wb_dat_i[7:0] & `UAR_WM_TXS;
        default: ;
      endcase
    end
    // read data, unmapped addresses read as zero
    // the fifo pops on the same edge that registers the returned byte
    if (rd) begin
      case (wb_adr_i)
        `UAR_ADR_BCON: dat_next[7:0] = {bcon_reg[7], state_reg == RX_IDLE, bcon_reg[5:0]};
        `UAR_ADR_ICON: dat_next[7:0] = icon_reg;
        `UAR_ADR_IPR:  dat_next[7:0] = ipr_reg;
        `UAR_ADR_PIE:  dat_next[7:0] = pie_reg;
        `UAR_ADR_PIR:  dat_next[7:0] = {pir_reg[7:6], receive_int_flag, transmit_int_flag, pir_reg[3:0]};
        `UAR_ADR_RCS:  dat_next[7:0] = {rcs_reg[7:3], top[9] & receive_int_flag, overrun_error_reg, top[8] & receive_int_flag};
        `UAR_ADR_BRL:  dat_next[7:0] = brl_reg;
        `UAR_ADR_BRH:  dat_next[7:0] = brh_reg;
        `UAR_ADR_TXS:  dat_next[7:0] = {txs_reg[7:2], left_reg == 4'h0, txs_reg[0]};
        `UAR_ADR_RXD:  begin
          dat_next[7:0] = top[7:0];
          pop = receive_int_flag;
        end
        default: ;
      endcase
    end
    // oversampling tick from divisor
    // reload while the port is off so the first tick is a full period away
    if (!serial_port_enable) begin
      brg_next = div;
    end else if (brg_reg == 16'h0000) begin
      brg_next  = div;
      tick_next = 1'b1;
    end else begin
      brg_next = brg_reg - 16'h0001;
    end
    // receiver sequence, sixteen ticks per bit
    if (!rx_en) begin
      state_next = RX_IDLE;
    end else if (state_reg == RX_IDLE) begin
      tcnt_next = 4'h0;
      if (!overrun_error_reg && prev_reg && !line_reg) begin
        state_next = RX_START;
      end
    end else if (tick_reg) begin
      tcnt_next = tcnt_reg + 4'h1;
      if (tcnt_reg == `UAR_SAMP_A) begin
        samp_next[0] = line_reg;
      end
      if (tcnt_reg == `UAR_SAMP_B) begin
        samp_next[1] = line_reg;
      end
      case (state_reg)
        RX_START: begin
          // line high at the half-bit point: noise, drop it without an error
          if (tcnt_reg == `UAR_SAMP_C && maj) begin
            state_next = RX_IDLE;
          end else if (tcnt_reg == `UAR_TICK_LAST) begin
            state_next = RX_DATA;
            bcnt_next  = 4'h0;
          end
        end
        RX_DATA: begin
          if (tcnt_reg == `UAR_SAMP_C) begin
            rsr_next  = {maj, rsr_reg[8:1]};
            bcnt_next = bcnt_reg + 4'h1;
          end else if (tcnt_reg == `UAR_TICK_LAST &&
                       bcnt_reg == (nine_rx ? `UAR_BITS_9 : `UAR_BITS_8)) begin
            state_next = RX_STOP;
          end
        end
        RX_STOP: begin
          if (tcnt_reg == `UAR_SAMP_C) begin
            state_next = RX_IDLE;
            if (!(address_detect_enable && nine_rx && !rsr_reg[8])) begin
              // a read in this same cycle frees a slot, so the character fits
              if (cnt_reg == `UAR_FIFO_FULL && !pop) begin
                overrun_error_next = 1'b1;
              end else begin
                push = 1'b1;
              end
            end
          end
        end
        default: state_next = RX_IDLE;
      endcase
    end
    // fifo of two characters
    if (push) begin
      mem_next[wptr_reg] = newc;
      wptr_next = ~wptr_reg;
    end
    if (pop) begin
      rptr_next = ~rptr_reg;
    end
    // push and pop together leave the count unchanged
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    // dropping continuous receive clears overrun, the fifo keeps its characters
    if (!continuous_receive_enable) begin
      overrun_error_next = 1'b0;
    end
    // port disable empties the fifo and forgets any overrun
    if (!serial_port_enable) begin
      cnt_next  = 2'h0;
      wptr_next = 1'b0;
      rptr_next = 1'b0;
      overrun_error_next = 1'b0;
    end
    // transmitter: holding register then shift register
    // a write while the holding register is full is dropped; software polls the flag
    if (wr && wb_adr_i == `UAR_ADR_TXH && tx_en && !full_reg) begin
      hold_next = {txs_reg[`UAR_TS_TRANSMIT_NINTH_BIT], wb_dat_i[7:0]};
      full_next = 1'b1;
    end
    if (!tx_en) begin
      full_next = 1'b0;
      left_next = 4'h0;
    end else if (left_reg == 4'h0 && full_reg) begin
      tsr_next  = {1'b1, nine_tx ? hold_reg[8] : 1'b1, hold_reg[7:0], 1'b0};
      left_next = nine_tx ? `UAR_FRAME_9 : `UAR_FRAME_8;
      ttck_next = 4'h0;
      full_next = 1'b0;
    end else if (left_reg != 4'h0 && tick_reg) begin
      ttck_next = ttck_reg + 4'h1;
      if (ttck_reg == `UAR_TICK_LAST) begin
        tsr_next  = {1'b1, tsr_reg[10:1]};
        left_next = left_reg - 4'h1;
      end
    end
    // line level and pin enable follow next-cycle values so they move with the state
    txo_next = ((left_next == 4'h0) | tsr_next[0]) ^ bcon_reg[`UAR_BC_TRANSMIT_POLARITY];
    oen_next = ~rcs_next[`UAR_RS_SERIAL_PORT_ENABLE];
    // request needs both global enables and the source's own enable
    irq_next = icon_reg[`UAR_IC_GIE] & icon_reg[`UAR_IC_PERIPHERAL_INT_ENABLE] &
               ((transmit_int_flag & pie_reg[`UAR_P1_TX]) | (receive_int_flag & pie_reg[`UAR_P1_RC]));
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcon_reg  <= `UAR_RST_BYTE;
      icon_reg  <= `UAR_RST_BYTE;
      ipr_reg   <= `UAR_RST_BYTE;
      pie_reg   <= `UAR_RST_BYTE;
      pir_reg   <= `UAR_RST_BYTE;
      rcs_reg   <= `UAR_RST_BYTE;
      brl_reg   <= `UAR_RST_BYTE;
      brh_reg   <= `UAR_RST_BYTE;
      txs_reg   <= `UAR_RST_BYTE;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      irq_reg   <= 1'b0;
      brg_reg   <= 16'h0000;
      tick_reg  <= 1'b0;
      state_reg <= RX_IDLE;
      tcnt_reg  <= 4'h0;
      bcnt_reg  <= 4'h0;
      samp_reg  <= 2'h3;
      rsr_reg   <= 9'h000;
      line_reg  <= 1'b1;
      prev_reg  <= 1'b1;
      mem_reg[0] <= 10'h000;
      mem_reg[1] <= 10'h000;
      wptr_reg  <= 1'b0;
      rptr_reg  <= 1'b0;
      cnt_reg   <= 2'h0;
      overrun_error_reg  <= 1'b0;
      hold_reg  <= 9'h000;
      full_reg  <= 1'b0;
      tsr_reg   <= 11'h7FF;
      left_reg  <= 4'h0;
      ttck_reg  <= 4'h0;
      txo_reg   <= 1'b1;
      oen_reg   <= 1'b1;
    end else begin
      bcon_reg  <= bcon_next;
      icon_reg  <= icon_next;
      ipr_reg   <= ipr_next;
      pie_reg   <= pie_next;
      pir_reg   <= pir_next;
      rcs_reg   <= rcs_next;
      brl_reg   <= brl_next;
      brh_reg   <= brh_next;
      txs_reg   <= txs_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      irq_reg   <= irq_next;
      brg_reg   <= brg_next;
      tick_reg  <= tick_next;
      state_reg <= state_next;
      tcnt_reg  <= tcnt_next;
      bcnt_reg  <= bcnt_next;
      samp_reg  <= samp_next;
      rsr_reg   <= rsr_next;
      line_reg  <= line_next;
      prev_reg  <= prev_next;
      mem_reg   <= mem_next;
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      cnt_reg   <= cnt_next;
      overrun_error_reg  <= overrun_error_next;
      hold_reg  <= hold_next;
      full_reg  <= full_next;
      tsr_reg   <= tsr_next;
      left_reg  <= left_next;
      ttck_reg  <= ttck_next;
      txo_reg   <= txo_next;
      oen_reg   <= oen_next;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o                 = ack_reg;
  assign wb_dat_o                 = dat_reg;
  assign irq_o                    = irq_reg;
  assign transmit_line_pin_o      = txo_reg;
  assign transmit_line_pin_oe_n_o = oen_reg;

  // checks on the receiver, fifo, flags and bus
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus answers one cycle after the request and idles with zero data
  bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero between answers");
  // transmit flag as software reads it, and the interrupt it raises
  transmit_int_flag_enable_a: assert property (rd && wb_adr_i == `UAR_ADR_PIR && tx_en && !full_reg
    |=> wb_dat_o[`UAR_P1_TX]) else $error("transmit flag not set by enable");
  tx_irq_a: assert property (transmit_int_flag && pie_reg[`UAR_P1_TX] && icon_reg[`UAR_IC_GIE] && icon_reg[`UAR_IC_PERIPHERAL_INT_ENABLE]
    |=> irq_o) else $error("transmit interrupt not raised");
  // receiver gating and pin drive
  rx_gate_a: assert property (!rx_en |=> state_reg == RX_IDLE) else $error("receiver ran while disabled");
  pin_drive_a: assert property (serial_port_enable |-> !transmit_line_pin_oe_n_o) else $error("pin not driven");
  start_abort_a: assert property (state_reg == RX_START && tick_reg && tcnt_reg == `UAR_SAMP_C && maj && rx_en
    |=> state_reg == RX_IDLE && cnt_reg == $past(cnt_reg) - {1'b0, $past(pop)}) else $error("bad start kept");
  fifo_bound_a: assert property (cnt_reg <= `UAR_FIFO_FULL) else $error("fifo over two");
  rx_pop_a: assert property (rd && wb_adr_i == `UAR_ADR_RXD && receive_int_flag && !push && serial_port_enable
    |=> cnt_reg == $past(cnt_reg) - 2'h1 ##0 wb_dat_o[7:0] == $past(top[7:0])) else $error("read did not pop");
  overrun_error_hold_a: assert property (overrun_error_reg && state_reg == RX_IDLE |=> state_reg == RX_IDLE)
    else $error("reception after overrun");
  overrun_error_clear_a: assert property (!continuous_receive_enable |=> !overrun_error_reg) else $error("overrun not cleared");
  // status of the oldest character and the flag a new one raises
  framing_error_read_a: assert property (rd && wb_adr_i == `UAR_ADR_RCS && receive_int_flag
    |=> wb_dat_o[`UAR_RS_FRAMING_ERROR] == $past(top[9])) else $error("framing status not from oldest character");
  receive_int_flag_track_a: assert property (push |=> receive_int_flag) else $error("receive flag not set by new character");

  // main scenarios: full fifo, overrun, aborted start, framing error, nine-bit send
  full_c: cover property (cnt_reg == `UAR_FIFO_FULL);
  ovr_c: cover property ($rose(overrun_error_reg));
  abort_c: cover property (state_reg == RX_START ##1 state_reg == RX_IDLE);
  frame_c: cover property (push && newc[9]);
  tx9_c: cover property (left_reg == `UAR_FRAME_9);
endmodule // uar_core
`default_nettype wire

// >>> core/uar_pkg.sv
// types shared by the serial receiver design
package uar_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uar_rx_state_e;
  typedef logic [9:0] uar_char_t; // {framing error, ninth bit, data byte}
endpackage

// >>> core/uar_regs.svh
// register map, field positions and timing constants for the serial receiver
// How it works
// - setting transmit enable sets the transmit flag, holding register empty.
// - transmit interrupt fires at once when enables and flag are all set.
// - ninth bit one marks the low byte as an address character.
// - line oversampled at sixteen ticks per bit, shift register once per bit.
// - receiver runs only with continuous receive, async mode and port enabled.
// - while the port is enabled the transmit pin is always driven.
// - a falling edge on the receive line starts a character.
// - half a bit later the line is checked; nonzero aborts silently.
// - each later bit is majority-sampled one bit time on and shifted in.
// - stop position sampled one bit later; zero sets framing error.
// - completed character enters the FIFO and raises the receive flag.
// - FIFO holds two characters while a third is shifting in.
// - reading receive data returns and removes the oldest character.
// - after overrun no further characters are accepted until cleared.
// - receive polarity one inverts received idle and data levels.
// - receive flag is read-only and shows an unread character.
// - receive flag follows FIFO; interrupt needs all three enables.
// - frames are idle mark, zero start, 8 or 9 bits lsb first, stop one.
// - third character into a full FIFO sets overrun; enables clear it.
// - framing error and ninth bit track the oldest unread character.
// - address detect in 9-bit mode keeps only ninth-bit-one characters.
`ifndef UAR_REGS_SVH
`define UAR_REGS_SVH
// register byte addresses
`define UAR_ADR_BCON 8'h00
`define UAR_ADR_ICON 8'h04
`define UAR_ADR_IPR  8'h08
`define UAR_ADR_PIE  8'h0C
`define UAR_ADR_PIR  8'h10
`define UAR_ADR_RCS  8'h14
`define UAR_ADR_BRL  8'h18
`define UAR_ADR_BRH  8'h1C
`define UAR_ADR_TXH  8'h20
`define UAR_ADR_TXS  8'h24
`define UAR_ADR_RXD  8'h28
// writable bit masks
`define UAR_WM_BCON 8'h3B
`define UAR_WM_RCS  8'hF8
`define UAR_WM_TXS  8'hFD
`define UAR_WM_PIR  8'h4F
// field positions
`define UAR_BC_RCIDL 6
`define UAR_BC_RECEIVE_POLARITY 5
`define UAR_BC_TRANSMIT_POLARITY 4
`define UAR_BC_SIXTEEN_BIT_DIVISOR_SELECT 3
`define UAR_IC_GIE   7
`define UAR_IC_PERIPHERAL_INT_ENABLE  6
`define UAR_P1_RC    5
`define UAR_P1_TX    4
`define UAR_RS_SERIAL_PORT_ENABLE  7
`define UAR_RS_RX9   6
`define UAR_RS_CONTINUOUS_RECEIVE_ENABLE  4
`define UAR_RS_ADDRESS_DETECT_ENABLE 3
`define UAR_RS_FRAMING_ERROR  2
`define UAR_RS_OVERRUN_ERROR  1
`define UAR_RS_RECEIVED_NINTH_BIT  0
`define UAR_TS_TX9   6
`define UAR_TS_TRANSMIT_ENABLE  5
`define UAR_TS_SYNC  4
`define UAR_TS_TRMT  1
`define UAR_TS_TRANSMIT_NINTH_BIT  0
// reset value of every byte register
`define UAR_RST_BYTE 8'h00
// oversampling: tick indices inside one bit cell
`define UAR_TICK_LAST 4'hF
`define UAR_SAMP_A    4'h7
`define UAR_SAMP_B    4'h8
`define UAR_SAMP_C    4'h9
// character lengths and frame lengths
`define UAR_BITS_8  4'h8
`define UAR_BITS_9  4'h9
`define UAR_FRAME_8 4'hA
`define UAR_FRAME_9 4'hB
`define UAR_FIFO_FULL 2'h2
`endif

// >>> tb/uar_core_tb_top.sv
// self-checking bench of the serial port core with a remote node model
`timescale 1ns/10ps
`default_nettype none
`include "uar_regs.svh"
module uar_core_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rx_line;
  logic        tx_line;
  logic        tx_oe_n;
  logic        irq_o;
  logic [31:0] q;
  logic [8:0]  cap;
  logic        ok;
  logic [7:0]  rng;
  logic [7:0]  held [3];
  int          n_fail;
  int          compares;
  int          bc;

  uar_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .receive_line_pin_i(rx_line),
    .transmit_line_pin_o(tx_line), .transmit_line_pin_oe_n_o(tx_oe_n), .irq_o(irq_o));
  uar_remote_node rn_u (.clk_i(clk_i), .tx_line_i(tx_line), .rx_line_o(rx_line));

  // 40 MHz system clock
  always #12.5 clk_i = ~clk_i;

  // 8-bit lfsr for random characters
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // clocks per bit: sixteen ticks of divisor plus one clocks
  function automatic int bit_time(input int div);
    return 16 * (div + 1);
  endfunction

  task automatic report_and_stop;
    $display("counts: %0d compares, %0d failures", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic we, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no bus ack", $time);
      report_and_stop();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 8'h00, r);
  endtask
  // status then data of the oldest character
  task automatic rx_chk(input logic [7:0] d, input logic fe);
    logic [31:0] r;
    rd(`UAR_ADR_RCS, r);
    chk(r[`UAR_RS_FRAMING_ERROR], fe, "framing error");
    rd(`UAR_ADR_RXD, r);
    chk(r, {24'h0, d}, "rx data");
  endtask
  task automatic flag_chk(input logic e);
    logic [31:0] r;
    rd(`UAR_ADR_PIR, r);
    chk(r[`UAR_P1_RC], e, "rx flag");
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  // main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    n_fail = 0;
    compares = 0;
    rng = 8'h41;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (held[i]) held[i] = 8'h00;
    for (int i = 0; i < 5; i++) begin
      rd((i == 4) ? 8'hFC : 8'(4 + 4 * i), q);
      chk(q, 32'h0, "reset or unmapped read");
    end
    chk({tx_line, tx_oe_n}, 2'h3, "pins idle after reset");
    endt("reset");
    bc = bit_time(1);
    rn_u.set_cfg(1'b0, bc);
    wr(`UAR_ADR_BRL, 8'h01);
    wr(`UAR_ADR_RCS, 8'h90);
    repeat (2) @(posedge clk_i);
    chk(tx_oe_n, 1'b0, "tx pin driven");
    wr(`UAR_ADR_TXS, 8'h20);
    rd(`UAR_ADR_PIR, q);
    chk(q[`UAR_P1_TX], 1'b1, "tx flag on enable");
    wr(`UAR_ADR_PIE, 8'h10);
    wr(`UAR_ADR_ICON, 8'hC0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1, "tx irq at once");
    wr(`UAR_ADR_PIE, 8'h00);
    endt("tx enable");
    for (int k = 0; k < 6; k++) begin
      rng = lfsr_next(rng);
      held[0] = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rng;
      rn_u.send({1'b0, held[0]}, 8, 1'b1);
      flag_chk(1'b1);
      rx_chk(held[0], 1'b0);
    end
    endt("random rx");
    rn_u.send(9'h0C3, 8, 1'b1);
    wr(`UAR_ADR_PIE, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1, "rx irq");
    wr(`UAR_ADR_ICON, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0, "rx irq masked");
    flag_chk(1'b1);
    rx_chk(8'hC3, 1'b0);
    endt("rx irq");
    rn_u.glitch(bc / 4);
    repeat (bc * 12) @(posedge clk_i);
    flag_chk(1'b0);
    rn_u.send(9'h096, 8, 1'b1);
    rx_chk(8'h96, 1'b0);
    rn_u.send(9'h055, 8, 1'b0);
    rn_u.send(9'h0AA, 8, 1'b1);
    rx_chk(8'h55, 1'b1);
    rx_chk(8'hAA, 1'b0);
    endt("start abort and framing");
    for (int k = 0; k < 3; k++) begin
      rng = lfsr_next(rng);
      held[k] = rng;
      rn_u.send({1'b0, rng}, 8, 1'b1);
    end
    rd(`UAR_ADR_RCS, q);
    chk(q[`UAR_RS_OVERRUN_ERROR], 1'b1, "overrun set");
    rx_chk(held[0], 1'b0);
    rx_chk(held[1], 1'b0);
    rn_u.send(9'h011, 8, 1'b1);
    flag_chk(1'b0);
    wr(`UAR_ADR_RCS, 8'h80);
    rd(`UAR_ADR_RCS, q);
    chk(q[`UAR_RS_OVERRUN_ERROR], 1'b0, "overrun cleared");
    rn_u.send(9'h022, 8, 1'b1);
    flag_chk(1'b0);
    endt("fifo overrun");
    wr(`UAR_ADR_BCON, 8'h20);
    rn_u.set_cfg(1'b1, bc);
    wr(`UAR_ADR_RCS, 8'h90);
    rn_u.send(9'h0E1, 8, 1'b1);
    rx_chk(8'hE1, 1'b0);
    wr(`UAR_ADR_RCS, 8'h80);
    wr(`UAR_ADR_BCON, 8'h00);
    rn_u.set_cfg(1'b0, bc);
    endt("rx polarity");
    wr(`UAR_ADR_RCS, 8'hD8);
    rn_u.send(9'h05A, 9, 1'b1);
    flag_chk(1'b0);
    rn_u.send(9'h1A5, 9, 1'b1);
    rd(`UAR_ADR_RCS, q);
    chk(q[`UAR_RS_RECEIVED_NINTH_BIT], 1'b1, "ninth bit status");
    rx_chk(8'hA5, 1'b0);
    endt("address detect");
    wr(`UAR_ADR_TXS, 8'h61);
    fork
      rn_u.capture(9, cap, ok);
      wr(`UAR_ADR_TXH, 8'h3C);
    join
    chk(ok, 1'b1, "tx start seen");
    chk(cap, 9'h13C, "tx 9-bit frame");
    endt("tx 9-bit");
    wr(`UAR_ADR_TXS, 8'h00);
    wr(`UAR_ADR_BCON, 8'h10);
    wr(`UAR_ADR_TXS, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(tx_line, 1'b0, "tx idle inverted");
    endt("tx polarity");
    report_and_stop();
  end
endmodule // uar_core_tb_top
`default_nettype wire

// >>> tb/uar_remote_node.sv
// remote serial node model: drives the receive line and captures the transmit line
`timescale 1ns/10ps
`default_nettype none
module uar_remote_node (
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  logic inv;      // line polarity seen by the receiver
  int   bit_clks; // clocks per bit cell
  // idle mark until the bench asks for traffic
  initial begin
    inv = 1'b0;
    bit_clks = 32;
    rx_line_o = 1'b1;
  end
  // polarity and bit time; line returns to idle mark at once
  task automatic set_cfg(input logic p, input int bc);
    inv = p;
    bit_clks = bc;
    rx_line_o <= ~p;
  endtask
  // one frame: zero start, data lsb first, one stop cell, idle mark after
  task automatic send(input logic [8:0] d, input int nb, input logic stop_v);
    rx_line_o <= inv;
    repeat (bit_clks) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      rx_line_o <= d[i] ^ inv;
      repeat (bit_clks) @(posedge clk_i);
    end
    rx_line_o <= stop_v ^ inv;
    repeat (bit_clks) @(posedge clk_i);
    rx_line_o <= ~inv; // short idle mark so the next start edge is seen
    repeat (2) @(posedge clk_i);
  endtask
  // short low pulse that must not pass as a start bit
  task automatic glitch(input int n);
    rx_line_o <= inv;
    repeat (n) @(posedge clk_i);
    rx_line_o <= ~inv;
  endtask
  // capture one transmitted frame at bit centres, ninth bit included
  task automatic capture(input int nb, output logic [8:0] d, output logic ok);
    int n;
    n = 0;
    d = 9'h000;
    while (tx_line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    ok = (n < 4000);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      d[i] = tx_line_i;
    end
    repeat (bit_clks) @(posedge clk_i);
  endtask
endmodule // uar_remote_node
`default_nettype wire
